//--- lsfrd_consts.svh
// Constants for the sync-flood and retry-disconnect link state block.
// Assumes a 200 MHz core clock (5 ns period); times are given in ns.
`ifndef LSFRD_CONSTS_SVH
`define LSFRD_CONSTS_SVH

// Core clock period in ps.
`define LSFRD_CLK_PS 5000
// Least no-operation time after the disconnect packet, in ns.
`define LSFRD_NOP_MIN_NS 200
// Longest no-operation time after the disconnect packet, in ns.
`define LSFRD_NOP_MAX_NS 300
// Longest time for the receiver to hold its eye position, in ns.
`define LSFRD_HOLD_MAX_NS 100
// Least no-operation count, rounded up to whole cycles (plus one for "more than").
`define LSFRD_NOP_MIN_CYC ((`LSFRD_NOP_MIN_NS * 1000 + `LSFRD_CLK_PS - 1) / `LSFRD_CLK_PS + 1)
// Longest no-operation count, rounded down.
`define LSFRD_NOP_MAX_CYC ((`LSFRD_NOP_MAX_NS * 1000) / `LSFRD_CLK_PS)
// Eye-hold deadline, rounded down.
`define LSFRD_HOLD_MAX_CYC ((`LSFRD_HOLD_MAX_NS * 1000) / `LSFRD_CLK_PS)
// Consecutive sync packets that force a sync flood.
`define LSFRD_SYNC_RUN 3'h4
// Register offsets (byte addresses).
`define LSFRD_REG_CTRL 8'h00
`define LSFRD_REG_LIMIT 8'h04
`define LSFRD_REG_STATUS 8'h08
`define LSFRD_REG_COUNT 8'h0c
// Control register fields.
`define LSFRD_CTRL_FLOOD_EN 0
`define LSFRD_CTRL_TRANSMITTER_OFF_CONTROL 1
`define LSFRD_CTRL_EOC 2
`define LSFRD_CTRL_FLOOD_REQ 3
// Status register fields.
`define LSFRD_ST_LINK_FAILURE_FLAG 0
`define LSFRD_ST_CRCERR 1
// Reset values of the attempt limits.
`define LSFRD_SHORT_RST 8'h03
`define LSFRD_TOTAL_RST 8'h0f

`endif

//--- lsfrd_pkg.sv
// Types for the sync-flood and retry-disconnect link state block.
// Assumes the constants header is compiled alongside.
package lsfrd_pkg;
  // Link state; Gray codes along operational, retry, training, flood.
  typedef enum logic [2:0] {
    LSFRD_OPER = 3'h0,
    LSFRD_RETRY = 3'h1,
    LSFRD_TRAIN = 3'h3,
    LSFRD_FLOOD = 3'h2,
    LSFRD_DISC = 3'h6
  } lsfrd_state_e;

  // Transmit lane command bundle.
  typedef struct packed {
    logic scramble_en;  // Scramblers run.
    logic send_ones;    // Scrambled ones on control and command lanes.
    logic send_disc;    // One disconnect packet.
    logic send_nop;     // No-operation packets.
    logic nop_diag;     // Diagnostic bit of each no-operation packet.
    logic [3:0] nop_rel; // Buffer-release fields of each no-operation packet.
  } lsfrd_tx_s;

  // Receive side events from the operational state.
  typedef struct packed {
    logic proto_err;
    logic crc_err;
    logic decode_err;
    logic disp_err;
    logic sync_pkt;
    logic pkt_done;
  } lsfrd_rx_s;
endpackage

//--- lsfrd_core.sv
// Sync-flood and retry-disconnect states of a serial link state machine,
// with an AHB-Lite register slave. Assumes one slave on the bus, link
// events synchronous to hclk except the stop pin and the forwarded clock.
// Operation
// - Scramblers run unbroken into flood until reset
// - Flood on unrecoverable error or operational flood
// - Flood sends scrambled ones, clock running
// - Flood ignores receiver; only reset leaves
// - Initiator keeps flooding; failer retries then floods
// - Error flood: all links if enabled, else one
// - Operational flood always propagates to all links
// - Flood entry needs no packet boundary
// - Retry freezes ack pointer, drops packets, zeroes credits
// - Retry ignores disparity and decode errors
// - Stop pin: receiver holds eye within 100ns
// - Four consecutive sync packets force flood
// - Finish packet, one disconnect, nops 200-300ns
// - Stop pin: nops 200-300ns then disconnected
// - Count retries; both limits exceeded means flood
// - Short limit: full training time, else zero
// - Retry count waits over 200ns of nops
// - Never drive a static lane value
// - Retry nops carry zero diag and release
// - Operational receive errors enter retry
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "lsfrd_consts.svh"

module lsfrd_core
  import lsfrd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic link_stop_pin_n,
  input wire logic link_clk_in,
  input wire lsfrd_rx_s rx_evt,
  input wire logic train_fail,
  input wire logic peer_flood_in,
  input wire logic tx_pkt_busy,
  output lsfrd_tx_s tx_cmd,
  output lsfrd_state_e link_state,
  output logic flood_all_links,
  output logic rx_ignore,
  output logic rx_hold_eye,
  output logic ack_ptr_freeze,
  output logic fwd_stomp,
  output logic credits_zero,
  output logic first_training_start,
  output logic first_training_full,
  output logic link_clk_seen
);

  // Current state and its next value.
  lsfrd_state_e state_r;
  lsfrd_state_e state_nxt;
  // Cycles of no-operation packets sent in retry.
  logic [7:0] nop_cnt_r;
  // Cycles in retry with the stop pin seen asserted; holds at 255.
  logic [7:0] stop_cnt_r;
  // The single disconnect packet has gone out.
  logic disc_sent_r;
  // Consecutive sync packets seen in retry.
  logic [2:0] sync_cnt_r;
  // Attempt counters.
  // Retry count, reported in the low byte of the count register.
  logic [7:0] retry_cnt_r;
  // Receive retry count, cleared by a good operational packet.
  logic [7:0] rx_retry_cnt_r;
  // Software registers.
  // Control bits: flood enable, transmitter off, end of chain, flood request.
  logic [3:0] ctrl_r;
  logic [7:0] short_lim_r;
  logic [7:0] total_lim_r;
  // Sticky failure flags, cleared only by reset.
  logic link_fail_r;
  logic crc_err_r;
  // Flood scope latched on entry.
  logic flood_all_r;
  // Training-entry outputs.
  logic train_go_r;
  logic train_full_r;
  // Synchronisers for the stop pin and the forwarded clock.
  logic [1:0] stop_sync_r;
  logic [1:0] lclk_sync_r;
  // Previous synchronised link clock level, for edge detection.
  logic lclk_prev_r;
  logic lclk_seen_r;
  // Bus data-phase capture.
  logic dp_wr_r;
  logic dp_rd_r;
  logic [7:0] dp_addr_r;
  logic [31:0] rdata_r;

  // Stop pin is active low; only the second flop is read.
  wire stop_req = ~stop_sync_r[1];
  // Operational receive error of any kind.
  wire oper_err = rx_evt.proto_err | rx_evt.crc_err | rx_evt.decode_err | rx_evt.disp_err;
  // Nops have run long enough to count the retry.
  wire nop_min_done = nop_cnt_r >= 8'(`LSFRD_NOP_MIN_CYC);
  // Nop window closes at its upper bound.
  wire nop_max_hit = nop_cnt_r >= 8'(`LSFRD_NOP_MAX_CYC);
  // Stop pin has been held long enough to leave for disconnected.
  wire stop_min_done = stop_cnt_r >= 8'(`LSFRD_NOP_MIN_CYC);
  // Limits are exceeded once the incremented count passes them.
  wire short_over = (retry_cnt_r + 8'h01) > short_lim_r;
  wire total_over = (rx_retry_cnt_r + 8'h01) > total_lim_r;
  // Fourth sync packet of an unbroken run.
  wire sync_four = rx_evt.sync_pkt && (sync_cnt_r == (`LSFRD_SYNC_RUN - 3'h1));
  // Software asks for a flood from the operational state.
  wire sw_flood = ctrl_r[`LSFRD_CTRL_FLOOD_REQ];
  // Link sits in the retry-disconnect state.
  wire in_retry = state_r == LSFRD_RETRY;
  // Retry completion without a stop request.
  wire retry_end = in_retry && disc_sent_r && !stop_req && nop_min_done;
  // Both attempt limits exceeded, so the retry escalates to a flood.
  wire retry_fail = retry_end && short_over && total_over;
  // Unrecoverable error from training or the retry state.
  wire unrec_err = (state_r == LSFRD_TRAIN && train_fail) || retry_fail;
  // Flood started or received while operational.
  wire oper_flood = state_r == LSFRD_OPER && (sw_flood || peer_flood_in);

  // Next-state selection.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LSFRD_OPER: begin
        if (oper_flood) begin
          state_nxt = LSFRD_FLOOD;
        end else if (oper_err) begin
          state_nxt = LSFRD_RETRY;
        end
      end
      LSFRD_RETRY: begin
        if (rx_evt.sync_pkt && sync_four) begin
          state_nxt = LSFRD_FLOOD;
        end else if (stop_req && disc_sent_r && stop_min_done) begin
          state_nxt = LSFRD_DISC;
        end else if (retry_fail) begin
          state_nxt = LSFRD_FLOOD;
        end else if (retry_end) begin
          state_nxt = LSFRD_TRAIN;
        end
      end
      LSFRD_TRAIN: begin
        // Training itself lies outside this block; only its outcome is seen.
        if (train_fail) begin
          state_nxt = LSFRD_FLOOD;
        end else if (rx_evt.pkt_done) begin
          state_nxt = LSFRD_OPER;
        end
      end
      LSFRD_FLOOD: begin
        state_nxt = LSFRD_FLOOD;
      end
      LSFRD_DISC: begin
        // Disconnected waits for the stop pin to be released.
        if (!stop_req) begin
          state_nxt = LSFRD_TRAIN;
        end
      end
      default: begin
        // An illegal code falls into flood, the safe state.
        state_nxt = LSFRD_FLOOD;
      end
    endcase
  end

  // State register; flood is left only through the reset pin.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= LSFRD_OPER;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Flood scope: all links for operational floods, per enable for unrecoverable errors; sync floods keep one link unless retry fails in that cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flood_all_r <= 1'b0;
    end else if (oper_flood) begin
      flood_all_r <= 1'b1;
    end else if (unrec_err) begin
      flood_all_r <= ctrl_r[`LSFRD_CTRL_FLOOD_EN];
    end
  end

  // Retry timers: disconnect once the current packet ends, then nops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disc_sent_r <= 1'b0;
      nop_cnt_r <= 8'h00;
      stop_cnt_r <= 8'h00;
    end else if (!in_retry) begin
      disc_sent_r <= 1'b0;
      nop_cnt_r <= 8'h00;
      stop_cnt_r <= 8'h00;
    end else begin
      if (!disc_sent_r && !tx_pkt_busy) begin
        disc_sent_r <= 1'b1;
      end
      if (disc_sent_r && !nop_max_hit) begin
        nop_cnt_r <= nop_cnt_r + 8'h01;
      end
      if (stop_req && stop_cnt_r != 8'hff) begin
        stop_cnt_r <= stop_cnt_r + 8'h01;
      end
    end
  end

  // Consecutive sync packet run; any other packet breaks it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_cnt_r <= 3'h0;
    end else if (!in_retry || (rx_evt.pkt_done && !rx_evt.sync_pkt)) begin
      sync_cnt_r <= 3'h0;
    end else if (rx_evt.sync_pkt && sync_cnt_r != 3'h7) begin
      sync_cnt_r <= sync_cnt_r + 3'h1;
    end
  end

  // Attempt counters and failure flags; flags are sticky to reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      retry_cnt_r <= 8'h00;
      rx_retry_cnt_r <= 8'h00;
      link_fail_r <= 1'b0;
      crc_err_r <= 1'b0;
    end else begin
      if (retry_end) begin
        retry_cnt_r <= retry_cnt_r + 8'h01;
        rx_retry_cnt_r <= rx_retry_cnt_r + 8'h01;
      end else if (state_r == LSFRD_OPER && rx_evt.pkt_done && !oper_err) begin
        rx_retry_cnt_r <= 8'h00;
      end
      if (retry_fail && ctrl_r[`LSFRD_CTRL_FLOOD_EN]) begin
        link_fail_r <= 1'b1;
      end
      if (retry_fail) begin
        crc_err_r <= 1'b1;
      end
    end
  end

  // Training entry: full training time only when the short limit alone is hit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      train_go_r <= 1'b0;
      train_full_r <= 1'b0;
    end else begin
      train_go_r <= retry_end && !retry_fail;
      train_full_r <= retry_end && !retry_fail && short_over;
    end
  end

  // Stop pin and forwarded clock synchronisers, with clock edge detect.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_sync_r <= 2'h3;
      lclk_sync_r <= 2'h0;
      lclk_prev_r <= 1'b0;
      lclk_seen_r <= 1'b0;
    end else begin
      stop_sync_r <= {stop_sync_r[0], link_stop_pin_n};
      lclk_sync_r <= {lclk_sync_r[0], link_clk_in};
      lclk_prev_r <= lclk_sync_r[1];
      lclk_seen_r <= lclk_sync_r[1] & ~lclk_prev_r;
    end
  end

  // Transmit commands: scramblers always on, so lanes never sit static.
  always_comb begin
    tx_cmd.scramble_en = 1'b1;
    tx_cmd.send_ones = state_r == LSFRD_FLOOD;
    tx_cmd.send_disc = in_retry && !disc_sent_r && !tx_pkt_busy;
    tx_cmd.send_nop = in_retry && disc_sent_r;
    tx_cmd.nop_diag = 1'b0;
    tx_cmd.nop_rel = 4'h0;
  end

  // Receiver controls.
  assign rx_ignore = state_r == LSFRD_FLOOD || in_retry;
  assign rx_hold_eye = in_retry && stop_req;
  assign ack_ptr_freeze = in_retry;
  assign fwd_stomp = in_retry;
  assign credits_zero = in_retry;
  assign flood_all_links = state_r == LSFRD_FLOOD && flood_all_r;
  assign link_state = state_r;
  assign first_training_start = train_go_r;
  assign first_training_full = train_full_r;
  assign link_clk_seen = lclk_seen_r;

  // Bus address phase decode.
  wire ap_valid = hsel && hready && htrans[1];
  wire [31:0] status_word = {24'h0, 3'h0, state_r, crc_err_r, link_fail_r};
  wire [31:0] count_word = {16'h0, rx_retry_cnt_r, retry_cnt_r};
  wire [31:0] rd_mux =
    (dp_addr_r == `LSFRD_REG_CTRL) ? {28'h0, ctrl_r} :
    (dp_addr_r == `LSFRD_REG_LIMIT) ? {16'h0, total_lim_r, short_lim_r} :
    (dp_addr_r == `LSFRD_REG_STATUS) ? status_word :
    (dp_addr_r == `LSFRD_REG_COUNT) ? count_word : 32'h0;

  // Capture the address phase for the following data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_rd_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      dp_wr_r <= ap_valid && hwrite;
      dp_rd_r <= ap_valid && !hwrite;
      if (ap_valid) begin
        dp_addr_r <= haddr;
      end
    end
  end

  // Register writes; software sets transmitter-off and end-of-chain.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= 4'h0;
      short_lim_r <= `LSFRD_SHORT_RST;
      total_lim_r <= `LSFRD_TOTAL_RST;
    end else if (dp_wr_r) begin
      if (dp_addr_r == `LSFRD_REG_CTRL) begin
        ctrl_r <= hwdata[3:0];
      end else if (dp_addr_r == `LSFRD_REG_LIMIT) begin
        short_lim_r <= hwdata[7:0];
        total_lim_r <= hwdata[15:8];
      end
    end
  end

  // Read data is registered at the data phase so it comes from a flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h0;
    end else if (ap_valid && !hwrite) begin
      rdata_r <= 32'h0;
    end else if (dp_rd_r) begin
      rdata_r <= rd_mux;
    end
  end

  // Reads take one wait state; writes complete with no wait.
  // High in the second data-phase cycle of a read.
  logic rd_wait_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait_r <= 1'b0;
    end else begin
      rd_wait_r <= dp_rd_r && !rd_wait_r;
    end
  end

  // Bus outputs; the response is always OKAY.
  assign hreadyout = !(dp_rd_r && !rd_wait_r);
  assign hrdata = rdata_r;
  assign hresp = 1'b0;

endmodule

//--- lsfrd_core_sva.sv
// Concurrent checks for the sync-flood and retry-disconnect block.
// Sees only the top-level ports; bound to every lsfrd_core instance.
`timescale 1ns/1ps
`include "lsfrd_consts.svh"
module lsfrd_chk
  import lsfrd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic link_stop_pin_n,
  input wire lsfrd_rx_s rx_evt,
  input wire logic peer_flood_in,
  input wire logic tx_pkt_busy,
  input wire lsfrd_tx_s tx_cmd,
  input wire lsfrd_state_e link_state,
  input wire logic flood_all_links,
  input wire logic rx_ignore,
  input wire logic rx_hold_eye,
  input wire logic ack_ptr_freeze,
  input wire logic fwd_stomp,
  input wire logic credits_zero,
  input wire logic first_training_start
);
  // Counts no-operation cycles in the current retry visit.
  logic [7:0] nop_cnt_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) nop_cnt_r <= 8'h00;
    else if (link_state != LSFRD_RETRY) nop_cnt_r <= 8'h00;
    else if (tx_cmd.send_nop) nop_cnt_r <= nop_cnt_r + 8'h01;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_flood_holds: assert property (link_state == LSFRD_FLOOD |=> link_state == LSFRD_FLOOD)
    else $error("flood state was left");
  a_flood_lanes: assert property (link_state == LSFRD_FLOOD |-> tx_cmd.send_ones && tx_cmd.scramble_en && rx_ignore)
    else $error("flood lanes wrong");
  a_oper_error: assert property (link_state == LSFRD_OPER && !peer_flood_in && link_stop_pin_n && (|rx_evt[5:2]) |=> link_state == LSFRD_RETRY)
    else $error("receive error did not start retry");
  a_peer_flood: assert property (link_state == LSFRD_OPER && peer_flood_in |=> link_state == LSFRD_FLOOD && flood_all_links)
    else $error("received flood not propagated");
  a_retry_rx: assert property (link_state == LSFRD_RETRY |-> ack_ptr_freeze && fwd_stomp && credits_zero && rx_ignore)
    else $error("retry receiver outputs wrong");
  a_nop_zero: assert property (link_state == LSFRD_RETRY && tx_cmd.send_nop |-> !tx_cmd.nop_diag && tx_cmd.nop_rel == 4'h0)
    else $error("retry nop fields not zero");
  a_disc_waits: assert property (link_state == LSFRD_RETRY && tx_pkt_busy |-> !tx_cmd.send_disc)
    else $error("disconnect cut a packet");
  a_sync_flood: assert property ((link_state == LSFRD_RETRY && rx_evt.sync_pkt) [*4] |=> link_state == LSFRD_FLOOD)
    else $error("sync run did not flood");
  a_nop_min: assert property (link_state == LSFRD_RETRY && tx_cmd.send_nop && nop_cnt_r < 8'(`LSFRD_NOP_MIN_CYC) |=> link_state != LSFRD_TRAIN)
    else $error("training entered too early");
  a_nop_max: assert property (link_state == LSFRD_RETRY && link_stop_pin_n |-> nop_cnt_r <= 8'(`LSFRD_NOP_MAX_CYC))
    else $error("nop period too long");
  a_eye_hold: assert property (link_state == LSFRD_RETRY && $fell(link_stop_pin_n) |-> ##[1:20] rx_hold_eye)
    else $error("eye hold too late");
  a_train_pulse: assert property (link_state == LSFRD_RETRY ##1 link_state == LSFRD_TRAIN |-> ##[0:1] first_training_start)
    else $error("training start missing");
  c_flood: cover property (link_state == LSFRD_FLOOD);
  c_train: cover property (link_state == LSFRD_RETRY ##1 link_state == LSFRD_TRAIN);
  c_disc: cover property (link_state == LSFRD_DISC);
endmodule

bind lsfrd_core lsfrd_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .link_stop_pin_n(link_stop_pin_n), .rx_evt(rx_evt), .peer_flood_in(peer_flood_in),
  .tx_pkt_busy(tx_pkt_busy), .tx_cmd(tx_cmd), .link_state(link_state),
  .flood_all_links(flood_all_links), .rx_ignore(rx_ignore), .rx_hold_eye(rx_hold_eye),
  .ack_ptr_freeze(ack_ptr_freeze), .fwd_stomp(fwd_stomp), .credits_zero(credits_zero),
  .first_training_start(first_training_start));

//--- lsfrd_peer.sv
// Peer link device model: receive events, flood and forwarded clock.
// Assumes events are hclk-synchronous and the reset is active low.
`timescale 1ns/1ps
module lsfrd_peer
  import lsfrd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  output lsfrd_rx_s rx_evt,
  output logic peer_flood_in,
  output logic link_clk_in
);
  // Quiet lines at time zero.
  initial begin
    rx_evt = '0;
    peer_flood_in = 1'b0;
    link_clk_in = 1'b0;
  end
  // The forwarded clock runs at its set rate in all these states.
  always #24 link_clk_in = ~link_clk_in;
  // A warm reset ends the flood on this side too.
  always @(negedge hresetn) peer_flood_in <= 1'b0;
  // Drives one event pattern for n cycles, then one quiet cycle.
  task automatic pulse(input lsfrd_rx_s ev, input int n);
    rx_evt <= ev;
    repeat (n) @(posedge hclk);
    #1;
    rx_evt <= '0;
    @(posedge hclk);
    #1;
  endtask
  // The side that starts a flood keeps it up until reset.
  task automatic flood();
    peer_flood_in <= 1'b1;
  endtask
endmodule

//--- testbench.sv
// Self-checking bench for lsfrd_core with a peer device model.
// Assumes the checker and peer files are compiled before it.
`timescale 1ns/1ps
`include "lsfrd_consts.svh"
module testbench
  import lsfrd_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, stop_n = 1'b1;
  logic train_fail = 1'b0, busy = 1'b0, hready, hreadyout, hresp, peer_flood, lclk;
  logic all_links, rx_ign, hold_eye, freeze, stomp, crz, ft_start, ft_full, seen;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd, seed = 32'hc;
  lsfrd_rx_s rx_evt;
  lsfrd_tx_s tx_cmd;
  lsfrd_state_e link_state;
  int n_errors = 0, check_count = 0, cyc = 0, seen_cnt = 0;
  // One slave, so its ready is the bus ready.
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  lsfrd_core u_lsfrd_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_stop_pin_n(stop_n),
    .link_clk_in(lclk), .rx_evt(rx_evt), .train_fail(train_fail), .peer_flood_in(peer_flood),
    .tx_pkt_busy(busy), .tx_cmd(tx_cmd), .link_state(link_state), .flood_all_links(all_links),
    .rx_ignore(rx_ign), .rx_hold_eye(hold_eye), .ack_ptr_freeze(freeze), .fwd_stomp(stomp),
    .credits_zero(crz), .first_training_start(ft_start), .first_training_full(ft_full),
    .link_clk_seen(seen));
  lsfrd_peer u_lsfrd_peer (.hclk(hclk), .hresetn(hresetn), .rx_evt(rx_evt),
    .peer_flood_in(peer_flood), .link_clk_in(lclk));
  // Counts link clock edges found and cuts a hung run short.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (seen === 1'b1) seen_cnt <= seen_cnt + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      print_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Outcome of a first retry: {flood, full training time}.
  function automatic logic [1:0] outcome(input logic [7:0] sh, input logic [7:0] tot);
    logic s_ex, t_ex;
    s_ex = (8'h01 > sh);
    t_ex = (8'h01 > tot);
    return {s_ex & t_ex, s_ex & ~t_ex};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One whole-word transfer; read data lands in rd.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    while (hreadyout !== 1'b1) tick(1);
    tick(1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    while (hreadyout !== 1'b1) tick(1);
    @(posedge hclk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    #1;
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    tick(3);
    stop_n <= 1'b1;
    hresetn <= 1'b1;
    tick(1);
  endtask
  // Error k while a packet is in flight, then the disconnect packet.
  task automatic enter_retry(input int k);
    lsfrd_rx_s ev;
    int w;
    ev = '0;
    ev[5 - k] = 1'b1;
    busy <= 1'b1;
    u_lsfrd_peer.pulse(ev, 1);
    chk("retry", LSFRD_RETRY, link_state);
    busy <= 1'b0;
    // The disconnect command stands for one cycle only, once busy has dropped.
    #1;
    for (w = 0; w < 8 && tx_cmd.send_disc !== 1'b1; w++) tick(1);
    chk("disc", 1'b1, tx_cmd.send_disc);
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    int t;
    logic fl;
    logic [7:0] sh, tot;
    logic [1:0] oc;
    do_reset();
    ahb(1'b0, `LSFRD_REG_LIMIT, 32'h0);
    chk("limits", 32'h00000f03, rd);
    ahb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    t = seen_cnt;
    tick(480);
    chk("clk edges", 1'b1, (seen_cnt - t) >= 49 && (seen_cnt - t) <= 51);
    // Each error kind, with limits on both sides of the bound.
    for (int i = 0; i < 4; i++) begin
      do_reset();
      rd = rnd();
      fl = rd[0];
      sh = (i == 0) ? 8'h01 : 8'h00;
      tot = (i == 2) ? 8'h00 : 8'h01 + {2'h0, rd[6:1]};
      oc = outcome(sh, tot);
      ahb(1'b1, `LSFRD_REG_CTRL, {31'h0, fl});
      ahb(1'b1, `LSFRD_REG_LIMIT, {16'h0, tot, sh});
      enter_retry(i);
      u_lsfrd_peer.pulse(lsfrd_rx_s'(6'h3c), 2);
      chk("ignored", LSFRD_RETRY, link_state);
      for (t = 0; t < 90 && link_state === LSFRD_RETRY && ft_start !== 1'b1; t++) tick(1);
      if (!oc[1]) begin
        for (t = 0; t < 3 && ft_start !== 1'b1; t++) tick(1);
        chk("full time", oc[0], ft_full);
        train_fail <= 1'b1;
        tick(1);
        train_fail <= 1'b0;
        tick(1);
      end
      chk("flood", LSFRD_FLOOD, link_state);
      chk("all links", fl, all_links);
      ahb(1'b0, `LSFRD_REG_COUNT, 32'h0);
      chk("counts", 32'h00000101, rd);
      ahb(1'b0, `LSFRD_REG_STATUS, 32'h0);
      chk("status", {27'h0, LSFRD_FLOOD, oc[1], fl & oc[1]}, rd);
    end
    // Three syncs then a packet, then a run of four.
    do_reset();
    enter_retry(rnd() % 4);
    u_lsfrd_peer.pulse(lsfrd_rx_s'(6'h02), 3);
    u_lsfrd_peer.pulse(lsfrd_rx_s'(6'h01), 1);
    chk("no flood", LSFRD_RETRY, link_state);
    u_lsfrd_peer.pulse(lsfrd_rx_s'(6'h02), 4);
    chk("sync flood", LSFRD_FLOOD, link_state);
    ahb(1'b1, `LSFRD_REG_CTRL, 32'h6);
    ahb(1'b0, `LSFRD_REG_CTRL, 32'h0);
    chk("ctrl", 32'h6, rd);
    // Flood received, then flood started by software.
    for (int j = 0; j < 2; j++) begin
      do_reset();
      if (j == 0) u_lsfrd_peer.flood();
      else ahb(1'b1, `LSFRD_REG_CTRL, 32'h8);
      tick(2);
      chk("oper flood", LSFRD_FLOOD, link_state);
      chk("propagate", 1'b1, all_links);
    end
    // Stop pin during retry.
    do_reset();
    enter_retry(1);
    stop_n <= 1'b0;
    tick(3);
    chk("hold eye", 1'b1, hold_eye);
    chk("nops", 1'b1, tx_cmd.send_nop);
    for (t = 3; t < 90 && link_state !== LSFRD_DISC; t++) tick(1);
    chk("disc time", 1'b1, t * 5 > `LSFRD_NOP_MIN_NS && t * 5 <= `LSFRD_NOP_MAX_NS);
    ahb(1'b0, `LSFRD_REG_COUNT, 32'h0);
    chk("no count", 32'h0, rd);
    do_reset();
    print_verdict();
  end
endmodule
